// ---- logic/drive_command_select_logic.sv ----
// Drive command selection: start, 3-wire, fault clear, mode and set selection.
// Assumes asynchronous contact and keypad inputs and a single-cycle register port.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module drive_command_select_logic
  import drive_cmd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Contact and keypad inputs
  input  wire logic        start_cw,
  input  wire logic        start_ccw,
  input  wire logic        arm_3wire,
  input  wire logic        keypad_unit_cw,
  input  wire logic        keypad_unit_ccw,
  input  wire logic        keypad_unit_arm,
  input  wire logic        err_ack,
  input  wire logic        fault_event,
  input  wire logic        torque_select,
  input  wire logic        param_set_sel2,
  input  wire logic        fixed_freq_sel1,
  input  wire logic        fixed_freq_sel2,
  input  wire logic        fixed_pct_sel1,
  input  wire logic        fixed_pct_sel2,
  input  wire logic        digital_input_four,
  // Drive commands
  output logic             run_cw,
  output logic             run_ccw,
  output logic             fault_active,
  output logic             torque_mode,
  output logic [1:0]       param_set,
  output logic [1:0]       fixed_freq,
  output logic [1:0]       fixed_pct
);
  typedef enum logic [1:0] {W_IDLE, W_CHECK, W_RUN} wstate_t;
  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] meta_r;
  logic [PIN_COUNT-1:0] sync_r;
  logic [PIN_COUNT-1:0] prev_r;
  logic [PIN_COUNT-1:0] rise;
  logic [7:0]  lr_mode_r;
  logic [7:0]  tmr_mode_r;
  logic [7:0]  tmr_t1_r;
  logic [7:0]  tmr_t2_r;
  logic [31:0] rdata_r;
  logic [31:0] status;
  logic [31:0] tick_cnt_r;
  logic        tick_r;
  logic [5:0]  ms_cnt_r;
  wstate_t     wstate_r;
  logic        dir_ccw_r;
  logic        fault_r;
  logic        run_cw_r;
  logic        run_ccw_r;
  logic        torque_r;
  logic [1:0]  pset_r;
  logic [1:0]  ffreq_r;
  logic [1:0]  fpct_r;
  logic        three_wire;
  logic        armed;
  logic        pulse_cw;
  logic        pulse_ccw;
  logic        rise_cw;
  logic        rise_ccw;
  logic        held_pulse;
  timer_link_if tlink ();
  function automatic logic [1:0] decode_sel(input logic s1, input logic s2);
    sel4_t r;
    case ({s2, s1})
      2'b00:   r = SEL_ONE;
      2'b01:   r = SEL_TWO;
      2'b11:   r = SEL_THREE;
      default: r = SEL_FOUR;
    endcase
    return r;
  endfunction
  assign pins_raw = {digital_input_four, fixed_pct_sel2, fixed_pct_sel1, fixed_freq_sel2,
                     fixed_freq_sel1, param_set_sel2, torque_select, fault_event, err_ack,
                     keypad_unit_arm, keypad_unit_ccw, keypad_unit_cw, arm_3wire, start_ccw, start_cw};
  // Two-stage synchronisers, then a delayed copy for edge detection
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_sync
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= pins_raw[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
      assign rise[gi] = sync_r[gi] & ~prev_r[gi];
    end
  endgenerate
  // Register port
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lr_mode_r  <= CTRL_LR_RST;
      tmr_mode_r <= TMR_MODE_RST;
      tmr_t1_r   <= TMR_T1_RST;
      tmr_t2_r   <= TMR_T2_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == REG_CTRL_ADDR)
        lr_mode_r <= reg_wdata[CTRL_LR_LSB +: CTRL_LR_W];
      else if (reg_addr == REG_TIMER_ADDR)
      begin
        tmr_mode_r <= reg_wdata[TMR_MODE_LSB +: TMR_FIELD_W];
        tmr_t1_r   <= reg_wdata[TMR_T1_LSB +: TMR_FIELD_W];
        tmr_t2_r   <= reg_wdata[TMR_T2_LSB +: TMR_FIELD_W];
      end
    end
  end

  always_comb
  begin
    status                          = 32'h0000_0000;
    status[ST_RUN_CW]               = run_cw_r;
    status[ST_RUN_CCW]              = run_ccw_r;
    status[ST_FAULT]                = fault_r;
    status[ST_TORQUE]               = torque_r;
    status[ST_PSET_LSB +: 2]        = pset_r;
    status[ST_FFREQ_LSB +: 2]       = ffreq_r;
    status[ST_FPCT_LSB +: 2]        = fpct_r;
    status[ST_TMR_OUT]              = tlink.out;
    status[ST_ARMED]                = armed;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_r <= 32'h0000_0000;
    else if (reg_rd && reg_addr == REG_CTRL_ADDR)
      rdata_r <= {24'h00_0000, lr_mode_r};
    else if (reg_rd && reg_addr == REG_TIMER_ADDR)
      rdata_r <= {8'h00, tmr_t2_r, tmr_t1_r, tmr_mode_r};
    else if (reg_rd && reg_addr == REG_STATUS_ADDR)
      rdata_r <= status;
    else
      rdata_r <= 32'h0000_0000;
  end
  assign reg_rdata = rdata_r;
  // Millisecond time base
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r     <= (tick_cnt_r >= TICK_CYCLES - 1);
      tick_cnt_r <= (tick_cnt_r >= TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end
  // Source selection by local/remote mode
  always_comb
  begin
    three_wire = (lr_mode_r == LR_3WIRE_CONTACTS) || (lr_mode_r == LR_3WIRE_KEYPAD);
    if (lr_mode_r == LR_3WIRE_KEYPAD)
    begin
      armed     = sync_r[PIN_ARM] | sync_r[PIN_KP_ARM];
      pulse_cw  = sync_r[PIN_CW] | sync_r[PIN_KP_CW];
      pulse_ccw = sync_r[PIN_CCW] | sync_r[PIN_KP_CCW];
      rise_cw   = rise[PIN_CW] | rise[PIN_KP_CW];
      rise_ccw  = rise[PIN_CCW] | rise[PIN_KP_CCW];
    end
    else
    begin
      armed     = three_wire & sync_r[PIN_ARM];
      pulse_cw  = sync_r[PIN_CW];
      pulse_ccw = sync_r[PIN_CCW];
      rise_cw   = rise[PIN_CW];
      rise_ccw  = rise[PIN_CCW];
    end
    held_pulse = dir_ccw_r ? pulse_ccw : pulse_cw;
  end
  // 3-wire sequence: arm, pulse, 32 ms check, latched run
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wstate_r  <= W_IDLE;
      dir_ccw_r <= 1'b0;
      ms_cnt_r  <= 6'h00;
    end
    else if (!three_wire || !armed || fault_r)
    begin
      wstate_r  <= W_IDLE;
      dir_ccw_r <= 1'b0;
      ms_cnt_r  <= 6'h00;
    end
    else
    begin
      case (wstate_r)
        W_IDLE:
          if (rise_cw || rise_ccw)
          begin
            wstate_r  <= (rise_cw && rise_ccw) ? W_IDLE : W_CHECK;
            dir_ccw_r <= rise_ccw & ~rise_cw;
            ms_cnt_r  <= 6'h00;
          end
        W_CHECK:
          if (!held_pulse)
            wstate_r <= W_IDLE;
          else if (dir_ccw_r ? rise_cw : rise_ccw)
            wstate_r <= W_IDLE;
          else if (ms_cnt_r >= 6'(PULSE_MIN_MS))
            wstate_r <= W_RUN;
          else if (tick_r)
            ms_cnt_r <= ms_cnt_r + 6'h01;
        W_RUN:
          wstate_r <= W_RUN;
        default:
          wstate_r <= W_IDLE;
      endcase
    end
  end
  // Drive commands; a fault blocks both directions
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_cw_r  <= 1'b0;
      run_ccw_r <= 1'b0;
    end
    else if (fault_r)
    begin
      run_cw_r  <= 1'b0;
      run_ccw_r <= 1'b0;
    end
    else if (three_wire)
    begin
      run_cw_r  <= (wstate_r != W_IDLE) && !dir_ccw_r;
      run_ccw_r <= (wstate_r != W_IDLE) && dir_ccw_r;
    end
    else
    begin
      // Opposing level commands cancel rather than pick a winner
      run_cw_r  <= sync_r[PIN_CW] & ~sync_r[PIN_CCW];
      run_ccw_r <= sync_r[PIN_CCW] & ~sync_r[PIN_CW];
    end
  end
  // Fault flag: a new fault beats a simultaneous acknowledge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_r <= 1'b0;
    else if (rise[PIN_FAULT])
      fault_r <= 1'b1;
    else if (rise[PIN_ERR_ACK])
      fault_r <= 1'b0;
  end
  // Selections; switching allowed while running
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      torque_r <= 1'b0;
      pset_r   <= 2'b00;
      ffreq_r  <= 2'b00;
      fpct_r   <= 2'b00;
    end
    else
    begin
      torque_r <= sync_r[PIN_TORQUE];
      pset_r   <= decode_sel(tlink.out, sync_r[PIN_PSET2]);
      ffreq_r  <= decode_sel(sync_r[PIN_FF1], sync_r[PIN_FF2]);
      fpct_r   <= decode_sel(sync_r[PIN_FP1], sync_r[PIN_FP2]);
    end
  end

  assign tlink.src   = sync_r[PIN_DIN4];
  assign tlink.tick  = tick_r;
  assign tlink.mode  = tmr_mode_r;
  assign tlink.time1 = tmr_t1_r;
  assign tlink.time2 = tmr_t2_r;
  signal_timer u_timer1
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lnk     (tlink.unit)
  );
  assign run_cw       = run_cw_r;
  assign run_ccw      = run_ccw_r;
  assign fault_active = fault_r;
  assign torque_mode  = torque_r;
  assign param_set    = pset_r;
  assign fixed_freq   = ffreq_r;
  assign fixed_pct    = fpct_r;
  sequence s_disarm;
    three_wire && !armed;
  endsequence
  sequence s_start_edge;
    three_wire && armed && !fault_r && wstate_r == W_IDLE && (rise_cw ^ rise_ccw);
  endsequence
  a_start_needs_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    !three_wire && !fault_r && !(sync_r[PIN_CW] ^ sync_r[PIN_CCW]) |=> !run_cw_r && !run_ccw_r)
    else $error("run without single start command");
  a_edge_starts: assert property (@(posedge clk) disable iff (sys_rst)
    s_start_edge |=> wstate_r == W_CHECK ##1 (run_cw_r || run_ccw_r) || wstate_r == W_IDLE)
    else $error("armed edge did not start");
  a_disarm_clears: assert property (@(posedge clk) disable iff (sys_rst)
    s_disarm |=> wstate_r == W_IDLE && !dir_ccw_r)
    else $error("latch kept after disarm");
  a_disarm_stops: assert property (@(posedge clk) disable iff (sys_rst)
    s_disarm |=> ##1 !run_cw_r && !run_ccw_r)
    else $error("drive kept running after disarm");
  a_run_ignores_edges: assert property (@(posedge clk) disable iff (sys_rst)
    wstate_r == W_RUN && three_wire && armed && !fault_r |=> wstate_r == W_RUN)
    else $error("run left on edge");
  a_short_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    wstate_r == W_CHECK && armed && three_wire && !held_pulse |=> wstate_r == W_IDLE)
    else $error("short pulse not stopped");
  a_both_pulses: assert property (@(posedge clk) disable iff (sys_rst)
    wstate_r == W_CHECK && armed && three_wire && held_pulse && (dir_ccw_r ? rise_cw : rise_ccw)
    |=> wstate_r == W_IDLE)
    else $error("coincident pulses not stopped");
  a_check_length: assert property (@(posedge clk) disable iff (sys_rst)
    wstate_r == W_CHECK |-> ms_cnt_r <= 6'(PULSE_MIN_MS))
    else $error("check window overran");
  a_ack_clears: assert property (@(posedge clk) disable iff (sys_rst)
    rise[PIN_ERR_ACK] && !rise[PIN_FAULT] |=> !fault_r)
    else $error("acknowledge did not clear fault");
  a_pset_decode: assert property (@(posedge clk) disable iff (sys_rst)
    tlink.out && !sync_r[PIN_PSET2] |=> pset_r == 2'b01)
    else $error("parameter set decode wrong");
endmodule

// ---- logic/drive_cmd_pkg.sv ----
// Constants for the drive command selection logic.
// Assumes a single 20 MHz control clock and a plain register port.
package drive_cmd_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned MS_TICK_CYCLES  = CLK_HZ / MS_PER_S;
  localparam int unsigned PULSE_MIN_MS    = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL_ADDR    = 8'h00;
  localparam logic [7:0] REG_TIMER_ADDR   = 8'h04;
  localparam logic [7:0] REG_STATUS_ADDR  = 8'h08;

  // Control register fields and reset values
  localparam int unsigned CTRL_LR_LSB     = 0;
  localparam int unsigned CTRL_LR_W       = 8;
  localparam logic [7:0]  CTRL_LR_RST     = 8'h00;

  // Timer register fields and reset values
  localparam int unsigned TMR_MODE_LSB    = 0;
  localparam int unsigned TMR_T1_LSB      = 8;
  localparam int unsigned TMR_T2_LSB      = 16;
  localparam int unsigned TMR_FIELD_W     = 8;
  localparam logic [7:0]  TMR_MODE_RST    = 8'h01;
  localparam logic [7:0]  TMR_T1_RST      = 8'h00;
  localparam logic [7:0]  TMR_T2_RST      = 8'h00;

  // Status register bit positions
  localparam int unsigned ST_RUN_CW       = 0;
  localparam int unsigned ST_RUN_CCW      = 1;
  localparam int unsigned ST_FAULT        = 2;
  localparam int unsigned ST_TORQUE       = 3;
  localparam int unsigned ST_PSET_LSB     = 4;
  localparam int unsigned ST_FFREQ_LSB    = 6;
  localparam int unsigned ST_FPCT_LSB     = 8;
  localparam int unsigned ST_TMR_OUT      = 10;
  localparam int unsigned ST_ARMED        = 11;

  // Local/remote selections that run 3-wire control
  localparam logic [7:0] LR_3WIRE_CONTACTS = 8'h05;
  localparam logic [7:0] LR_3WIRE_KEYPAD   = 8'h2E;

  // Timer operating modes
  localparam logic [7:0] TMR_OFF          = 8'h00;
  localparam logic [7:0] TMR_FALL_BASE    = 8'h0A;
  localparam logic [7:0] TMR_RETRIG       = 8'h02;
  localparam logic [7:0] TMR_AND          = 8'h03;

  // Synchronised pin vector positions
  localparam int unsigned PIN_CW          = 0;
  localparam int unsigned PIN_CCW         = 1;
  localparam int unsigned PIN_ARM         = 2;
  localparam int unsigned PIN_KP_CW       = 3;
  localparam int unsigned PIN_KP_CCW      = 4;
  localparam int unsigned PIN_KP_ARM      = 5;
  localparam int unsigned PIN_ERR_ACK     = 6;
  localparam int unsigned PIN_FAULT       = 7;
  localparam int unsigned PIN_TORQUE      = 8;
  localparam int unsigned PIN_PSET2       = 9;
  localparam int unsigned PIN_FF1         = 10;
  localparam int unsigned PIN_FF2         = 11;
  localparam int unsigned PIN_FP1         = 12;
  localparam int unsigned PIN_FP2         = 13;
  localparam int unsigned PIN_DIN4        = 14;
  localparam int unsigned PIN_COUNT       = 15;

  typedef enum logic [1:0] {SEL_ONE, SEL_TWO, SEL_THREE, SEL_FOUR} sel4_t;
endpackage

// ---- logic/timer_link_if.sv ----
// Carrier between the command logic and its timer stage.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface timer_link_if;
  logic       src;
  logic       tick;
  logic [7:0] mode;
  logic [7:0] time1;
  logic [7:0] time2;
  logic       out;

  modport ctl
  (
    output src, tick, mode, time1, time2,
    input  out
  );
  modport unit
  (
    input  src, tick, mode, time1, time2,
    output out
  );
endinterface

// ---- logic/signal_timer.sv ----
// Timer stage: delays and stretches a logic source.
// Assumes src is already synchronous to clk; tick is one cycle per time unit.
`timescale 1ns/1ps
module signal_timer
  import drive_cmd_pkg::*;
(
  // Clock and reset
  input wire logic      clk,
  input wire logic      sys_rst,
  // Link to the command logic
  timer_link_if.unit    lnk
);
  typedef enum logic [1:0] {T_IDLE, T_DELAY, T_ON} tstate_t;

  tstate_t    state_r;
  logic       src_d_r;
  logic [7:0] cnt_r;
  logic       out_r;
  logic [7:0] base;
  logic       edge_hit;
  logic       bypass;

  always_comb
  begin
    base     = (lnk.mode >= TMR_FALL_BASE) ? lnk.mode - TMR_FALL_BASE : lnk.mode;
    edge_hit = (lnk.mode >= TMR_FALL_BASE) ? (src_d_r & ~lnk.src) : (lnk.src & ~src_d_r);
    // Zero delay and duration make the stage transparent
    bypass   = (lnk.time1 == 8'h00) && (lnk.time2 == 8'h00);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      src_d_r <= 1'b0;
    else
      src_d_r <= lnk.src;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= T_IDLE;
      cnt_r   <= 8'h00;
    end
    else if (lnk.mode == TMR_OFF || bypass)
    begin
      state_r <= T_IDLE;
      cnt_r   <= 8'h00;
    end
    else
    begin
      case (state_r)
        T_IDLE:
          if (edge_hit)
          begin
            state_r <= T_DELAY;
            cnt_r   <= 8'h00;
          end
        T_DELAY:
          if ((base == TMR_RETRIG && edge_hit) || (base == TMR_AND && !lnk.src))
            cnt_r <= 8'h00;
          else if (cnt_r >= lnk.time1)
          begin
            state_r <= T_ON;
            cnt_r   <= 8'h00;
          end
          else if (lnk.tick)
            cnt_r <= cnt_r + 8'h01;
        T_ON:
          if ((cnt_r >= lnk.time2) || (base == TMR_AND && !lnk.src))
            state_r <= T_IDLE;
          else if (lnk.tick)
            cnt_r <= cnt_r + 8'h01;
        default:
          state_r <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      out_r <= 1'b0;
    else if (lnk.mode == TMR_OFF)
      out_r <= 1'b0;
    else if (bypass)
      out_r <= lnk.src;
    else
      out_r <= (state_r == T_ON);
  end

  assign lnk.out = out_r;
endmodule

// ---- bench/contact_panel.sv ----
// Model of the contact and keypad side that drives the command pins.
// Assumes the bench calls its tasks; pins change just after a rising edge.
`timescale 1ns/1ps
module contact_panel
  import drive_cmd_pkg::*;
(
  // Clock
  input  wire logic                 clk,
  // Contact and keypad pins
  output logic [PIN_COUNT-1:0]      pins
);
  initial pins = '0;

  // Set one contact level and hold it
  task automatic drive(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
  endtask

  // Close a contact for a number of cycles, then open it
  task automatic pulse(input int idx, input int cycles);
    drive(idx, 1'b1);
    repeat (cycles) @(posedge clk);
    pins[idx] <= 1'b0;
  endtask
endmodule

// ---- bench/drive_command_select_logic_test.sv ----
// Self-checking bench for the drive command selection logic.
// Assumes a short millisecond tick so 32 ms windows stay small.
`timescale 1ns/1ps
module drive_command_select_logic_test;
  import drive_cmd_pkg::*;
  localparam int TK = 4;
  logic                 clk;
  logic                 sys_rst;
  logic [7:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [31:0]          reg_rdata;
  logic [PIN_COUNT-1:0] pins;
  logic                 run_cw;
  logic                 run_ccw;
  logic                 fault_active;
  logic                 torque_mode;
  logic [1:0]           param_set;
  logic [1:0]           fixed_freq;
  logic [1:0]           fixed_pct;
  logic [31:0]          d;
  logic                 s1;
  logic                 s2;
  int                   num_errors;
  int                   num_checks;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  contact_panel panel (.clk(clk), .pins(pins));

  drive_command_select_logic #(.TICK_CYCLES(TK)) uut
  (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_cw(pins[PIN_CW]), .start_ccw(pins[PIN_CCW]),
    .arm_3wire(pins[PIN_ARM]), .keypad_unit_cw(pins[PIN_KP_CW]), .keypad_unit_ccw(pins[PIN_KP_CCW]),
    .keypad_unit_arm(pins[PIN_KP_ARM]), .err_ack(pins[PIN_ERR_ACK]), .fault_event(pins[PIN_FAULT]),
    .torque_select(pins[PIN_TORQUE]), .param_set_sel2(pins[PIN_PSET2]), .fixed_freq_sel1(pins[PIN_FF1]),
    .fixed_freq_sel2(pins[PIN_FF2]), .fixed_pct_sel1(pins[PIN_FP1]), .fixed_pct_sel2(pins[PIN_FP2]),
    .digital_input_four(pins[PIN_DIN4]), .run_cw(run_cw), .run_ccw(run_ccw), .fault_active(fault_active),
    .torque_mode(torque_mode), .param_set(param_set), .fixed_freq(fixed_freq), .fixed_pct(fixed_pct)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Let edge updates land before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic run_is(input logic cw, input logic ccw, input string msg);
    check(32'(run_cw), 32'(cw), msg);
    check(32'(run_ccw), 32'(ccw), msg);
  endtask

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    num_errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_CTRL_ADDR, d);
    check(d, {24'h0, CTRL_LR_RST}, "ctrl reset value");
    rd(REG_TIMER_ADDR, d);
    check(d, {8'h00, TMR_T2_RST, TMR_T1_RST, TMR_MODE_RST}, "timer reset value");
    rd(8'h0C, d);
    check(d, 32'h0, "unmapped read");
    wr(REG_STATUS_ADDR, 32'hFFFF_FFFF);
    rd(REG_STATUS_ADDR, d);
    check(d, 32'h0, "status is read only");
    $display("Test registers finished");
    // Selector order is 00, 01, 11, 10 for codes one to four
    for (int i = 0; i < 4; i++)
    begin
      s1 = (i == 1 || i == 2);
      s2 = (i >= 2);
      panel.drive(PIN_FF1, s1);
      panel.drive(PIN_FF2, s2);
      panel.drive(PIN_FP1, s1);
      panel.drive(PIN_FP2, s2);
      panel.drive(PIN_DIN4, s1);
      panel.drive(PIN_PSET2, s2);
      cyc(8);
      check(32'(fixed_freq), 32'(i), "fixed frequency");
      check(32'(fixed_pct), 32'(i), "fixed percentage");
      check(32'(param_set), 32'(i), "parameter set via timer");
      rd(REG_STATUS_ADDR, d);
      check(32'(d[5:4]), 32'(i), "parameter set status");
    end
    $display("Test selectors finished");
    // Source high and second selector low, so a blocked timer shows as set one
    panel.drive(PIN_PSET2, 1'b0);
    panel.drive(PIN_DIN4, 1'b1);
    wr(REG_TIMER_ADDR, {24'h0, TMR_OFF});
    cyc(8);
    check(32'(param_set), 32'h0, "timer off blocks source");
    wr(REG_TIMER_ADDR, {24'h0, TMR_MODE_RST});
    cyc(8);
    rd(REG_STATUS_ADDR, d);
    check(32'(d[ST_TMR_OUT]), 32'h1, "timer output follows source");
    check(32'(param_set), 32'h1, "zero times pass source");
    // Delay of 2 ticks, then an output period of 4 ticks
    panel.drive(PIN_DIN4, 1'b0);
    wr(REG_TIMER_ADDR, {8'h00, 8'h04, 8'h02, TMR_MODE_RST});
    cyc(8);
    panel.drive(PIN_DIN4, 1'b1);
    rd(REG_STATUS_ADDR, d);
    check(32'(d[ST_TMR_OUT]), 32'h0, "timer delay holds output");
    cyc(16);
    rd(REG_STATUS_ADDR, d);
    check(32'(d[ST_TMR_OUT]), 32'h1, "timer output after delay");
    cyc(20);
    rd(REG_STATUS_ADDR, d);
    check(32'(d[ST_TMR_OUT]), 32'h0, "timer period ended");
    panel.drive(PIN_TORQUE, 1'b1);
    cyc(8);
    check(32'(torque_mode), 32'h1, "torque control");
    panel.drive(PIN_TORQUE, 1'b0);
    cyc(8);
    check(32'(torque_mode), 32'h0, "speed control");
    $display("Test timer and control mode finished");
    panel.drive(PIN_CW, 1'b1);
    cyc(8);
    run_is(1'b1, 1'b0, "level start clockwise");
    panel.drive(PIN_CCW, 1'b1);
    cyc(8);
    run_is(1'b0, 1'b0, "both level starts");
    panel.drive(PIN_CW, 1'b0);
    cyc(8);
    run_is(1'b0, 1'b1, "level start anticlockwise");
    panel.drive(PIN_FAULT, 1'b1);
    cyc(8);
    check(32'(fault_active), 32'h1, "fault set");
    run_is(1'b0, 1'b0, "fault stops drive");
    panel.drive(PIN_FAULT, 1'b0);
    panel.drive(PIN_ERR_ACK, 1'b1);
    cyc(8);
    check(32'(fault_active), 32'h0, "fault acknowledged");
    panel.drive(PIN_ERR_ACK, 1'b0);
    panel.drive(PIN_CCW, 1'b0);
    cyc(8);
    run_is(1'b0, 1'b0, "no start command");
    $display("Test level start and fault finished");
    wr(REG_CTRL_ADDR, {24'h0, LR_3WIRE_CONTACTS});
    panel.pulse(PIN_CW, 40 * TK);
    cyc(8);
    run_is(1'b0, 1'b0, "pulse without arming");
    panel.drive(PIN_ARM, 1'b1);
    cyc(8);
    rd(REG_STATUS_ADDR, d);
    check(32'(d[ST_ARMED]), 32'h1, "armed status");
    panel.drive(PIN_CW, 1'b1);
    cyc(10);
    run_is(1'b1, 1'b0, "armed pulse starts");
    cyc(40 * TK);
    panel.drive(PIN_CW, 1'b0);
    cyc(10);
    run_is(1'b1, 1'b0, "direction latched");
    panel.drive(PIN_CCW, 1'b1);
    cyc(10);
    run_is(1'b1, 1'b0, "later edge ignored");
    panel.drive(PIN_CCW, 1'b0);
    panel.drive(PIN_ARM, 1'b0);
    cyc(8);
    run_is(1'b0, 1'b0, "disarm stops drive");
    panel.drive(PIN_ARM, 1'b1);
    panel.pulse(PIN_CCW, 10 * TK);
    cyc(10);
    run_is(1'b0, 1'b0, "short pulse stops drive");
    panel.drive(PIN_ARM, 1'b0);
    panel.drive(PIN_ARM, 1'b1);
    panel.drive(PIN_CW, 1'b1);
    cyc(5 * TK);
    panel.drive(PIN_CCW, 1'b1);
    cyc(40 * TK);
    run_is(1'b0, 1'b0, "both pulses in window");
    panel.drive(PIN_CW, 1'b0);
    panel.drive(PIN_CCW, 1'b0);
    panel.drive(PIN_ARM, 1'b0);
    $display("Test three wire contacts finished");
    panel.drive(PIN_KP_ARM, 1'b1);
    panel.drive(PIN_KP_CCW, 1'b1);
    cyc(10);
    run_is(1'b0, 1'b0, "keypad ignored in contact mode");
    panel.drive(PIN_KP_CCW, 1'b0);
    wr(REG_CTRL_ADDR, {24'h0, LR_3WIRE_KEYPAD});
    cyc(8);
    panel.drive(PIN_KP_CCW, 1'b1);
    cyc(10);
    run_is(1'b0, 1'b1, "keypad start");
    cyc(40 * TK);
    panel.drive(PIN_KP_CCW, 1'b0);
    panel.drive(PIN_KP_ARM, 1'b0);
    cyc(8);
    run_is(1'b0, 1'b0, "keypad disarm");
    $display("Test three wire keypad finished");
    conclude();
  end
endmodule
